// File: verilog/adcseq_regs.svh
`ifndef ADCSEQ_REGS_SVH
`define ADCSEQ_REGS_SVH

// Register word addresses
`define ADCSEQ_CTRL_OFS   4'h0
`define ADCSEQ_CLK_OFS    4'h4

// Control word fields
`define ADCSEQ_ON_BIT     15
`define ADCSEQ_RISE_BIT   8
`define ADCSEQ_SRC_HI     7
`define ADCSEQ_SRC_LO     4
`define ADCSEQ_AUTO_BIT   2
`define ADCSEQ_SAMPLE_ACTIVE_BIT   1
`define ADCSEQ_DONE_BIT   0

// Clock word fields
`define ADCSEQ_RC_BIT     15
`define ADCSEQ_STC_HI     12
`define ADCSEQ_STC_LO     8
`define ADCSEQ_PRE_HI     7
`define ADCSEQ_PRE_LO     0

// Reset values
`define ADCSEQ_CTRL_RST   16'h0000
`define ADCSEQ_CLK_RST    16'h0000

// Trigger source codes
`define ADCSEQ_SRC_SW     4'h0
`define ADCSEQ_SRC_PIN    4'h1
`define ADCSEQ_SRC_TMR    4'h2
`define ADCSEQ_SRC_AUTO   4'h7

// Conversion length in conversion clock periods
`define ADCSEQ_CONV_TAD   5'h0C

`endif

// File: verilog/adcseq_pkg.sv
`default_nettype none
package adcseq_pkg;

  // Sequencer phases
  typedef enum logic [1:0] {
    ADCSEQ_IDLE,
    ADCSEQ_SAMPLE,
    ADCSEQ_CONVERT
  } adcseq_state_t;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } adcseq_bus_t;

  // Conversion clock generator state
  typedef struct packed {
    logic [7:0] div;
    logic       s1;
    logic       s2;
    logic       s3;
    logic       lvl;
    logic       tick;
  } adcseq_tad_st_t;

  // Sequencer state
  typedef struct packed {
    adcseq_state_t state;
    logic          on;
    logic          rise;
    logic [3:0]    src;
    logic          auto_smp;
    logic          sample_active;
    logic          done;
    logic          rc_sel;
    logic [4:0]    stc;
    logic [7:0]    pre;
    logic [4:0]    cnt;
    logic          p1;
    logic          p2;
    logic          p3;
    logic          plvl;
    logic          tmr_eq;
    logic [15:0]   rdata;
    logic          sampling;
    logic          converting;
    logic          conv_start;
    logic          result_write;
    logic          chan_adv;
    logic          abort;
  } adcseq_st_t;

endpackage
`default_nettype wire

// File: verilog/adcseq_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_regs.svh"
module adcseq_tad_gen import adcseq_pkg::*; (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Configuration
  input  wire logic       enable,
  input  wire logic       rc_sel,
  input  wire logic [7:0] prescale,
  // RC oscillator pin
  input  wire logic       rc_osc,
  // One pulse per conversion clock period
  output logic            tick
);

  adcseq_tad_st_t q;
  adcseq_tad_st_t n;

  ////////////////////////////////////////////////////////////////////////
  // Divider or synchronised RC edge; stopped while powered down
  always_comb begin
    n      = q;
    n.tick = 1'b0;
    n.s1   = rc_osc;
    n.s2   = q.s1;
    n.s3   = q.s2;
    if (q.s2 == q.s3) begin
      n.lvl = q.s3;
    end
    if (!enable) begin
      n.div = 8'h00;
    end else if (rc_sel) begin
      n.tick = (q.s2 == q.s3) && q.s3 && !q.lvl;
    end else if (q.div >= prescale) begin
      // Period is prescale plus one system clocks
      n.div  = 8'h00;
      n.tick = 1'b1;
    end else begin
      n.div = q.div + 8'h01;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign tick = q.tick;

endmodule // adcseq_tad_gen
`default_nettype wire

// File: verilog/adcseq_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_regs.svh"

////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Setting sample_active with auto sampling off starts sampling.
// - Software source: clearing sample_active ends sampling and starts conversion.
// - Manual mode: no new sampling until software sets sample_active again.
// - Auto sampling: a new sampling phase starts when each conversion completes.
// - Auto sampling moves on to the next selected channel.
// - Auto with software source: hardware sets sample_active after conversion.
// - Done clears when sample_active clears, marking conversion start.
// - Inactive shows sample_active zero with done one.
// - Clearing auto enable finishes the sequence, then sampling stops.
// - Trigger source field at control bits 7 to 4 selects the event.
// - Clocked source counts sample_time_count periods, then converts.
// - Code 0111 with auto sampling runs sequences continuously.
// - Conversion clock from RC oscillator or prescaled instruction clock.
// - Each conversion lasts twelve conversion clock periods.
// - Up to sixteen event sources can end sampling.
// - Code 0001: programmable edge on the interrupt pin starts conversion.
// - Code 0010: 32-bit timer count matching its period starts conversion.
// - Converter off: powered down, registers keep their contents.
// - Turning off mid-conversion aborts it without a result write.
module adcseq_core import adcseq_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // Register port
  input  wire adcseq_bus_t bus,
  output logic [15:0]      rd_data,
  // Trigger sources
  input  wire logic [15:0] ext_trig,
  input  wire logic        ext_int_pin,
  input  wire logic [31:0] paired_timer_count,
  input  wire logic [31:0] paired_timer_period,
  // RC oscillator pin
  input  wire logic        rc_osc,
  // Converter control
  output logic             powered,
  output logic             sampling,
  output logic             converting,
  output logic             conv_start,
  output logic             result_write,
  output logic             chan_advance,
  output logic             conv_abort
);

  adcseq_st_t q;
  adcseq_st_t n;
  // Conversion clock tick and trigger events
  logic       tad_tick;
  logic       sw_clr;
  logic       pin_edge;
  logic       tmr_evt;
  logic       stc_hit;
  logic [15:0] trig_vec;
  logic       trig;

  // Register address match
  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // Register read image
  function automatic logic [15:0] rd_word(input logic [3:0] a, input adcseq_st_t s);
    logic [15:0] w;
    w = 16'h0000;
    if (reg_hit(a, `ADCSEQ_CTRL_OFS)) begin
      w[`ADCSEQ_ON_BIT]                 = s.on;
      w[`ADCSEQ_RISE_BIT]               = s.rise;
      w[`ADCSEQ_SRC_HI:`ADCSEQ_SRC_LO] = s.src;
      w[`ADCSEQ_AUTO_BIT]               = s.auto_smp;
      w[`ADCSEQ_SAMPLE_ACTIVE_BIT]               = s.sample_active;
      w[`ADCSEQ_DONE_BIT]               = s.done;
    end else if (reg_hit(a, `ADCSEQ_CLK_OFS)) begin
      w[`ADCSEQ_RC_BIT]                 = s.rc_sel;
      w[`ADCSEQ_STC_HI:`ADCSEQ_STC_LO] = s.stc;
      w[`ADCSEQ_PRE_HI:`ADCSEQ_PRE_LO] = s.pre;
    end
    rd_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Conversion clock; gated off with the converter to save power
  adcseq_tad_gen u_tad (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .enable   (q.on),
    .rc_sel   (q.rc_sel),
    .prescale (q.pre),
    .rc_osc   (rc_osc),
    .tick     (tad_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Event sources, computed from registered state, the bus write, the timer inputs and ext_trig
  always_comb begin
    sw_clr   = bus.wr && reg_hit(bus.addr, `ADCSEQ_CTRL_OFS)
               && !bus.wdata[`ADCSEQ_SAMPLE_ACTIVE_BIT];
    // Edge counts once the last two sync stages agree
    pin_edge = (q.p2 == q.p3) && (q.p3 != q.plvl) && (q.p3 == q.rise);
    tmr_evt  = (paired_timer_count == paired_timer_period) && !q.tmr_eq;
    // A count of one fires on the first tick after sampling starts
    stc_hit  = tad_tick && ((q.cnt + 5'h01) == q.stc);
    // Sixteen-way selector, fixed sources overlaid
    trig_vec                     = ext_trig;
    trig_vec[`ADCSEQ_SRC_SW]     = sw_clr;
    trig_vec[`ADCSEQ_SRC_PIN]    = pin_edge;
    trig_vec[`ADCSEQ_SRC_TMR]    = tmr_evt;
    trig_vec[`ADCSEQ_SRC_AUTO]   = stc_hit;
    trig                         = trig_vec[q.src];
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state: registers, synchronisers, sequencer
  always_comb begin
    n              = q;
    n.conv_start   = 1'b0;
    n.result_write = 1'b0;
    n.chan_adv     = 1'b0;
    n.abort        = 1'b0;
    n.rdata        = 16'h0000;
    n.p1           = ext_int_pin;
    n.p2           = q.p1;
    n.p3           = q.p2;
    if (q.p2 == q.p3) begin
      n.plvl = q.p3;
    end
    // Remembered so that a match lasting several cycles fires once
    n.tmr_eq = (paired_timer_count == paired_timer_period);

    // Software writes; done is read only
    if (bus.wr && reg_hit(bus.addr, `ADCSEQ_CTRL_OFS)) begin
      n.on       = bus.wdata[`ADCSEQ_ON_BIT];
      n.rise     = bus.wdata[`ADCSEQ_RISE_BIT];
      n.src      = bus.wdata[`ADCSEQ_SRC_HI:`ADCSEQ_SRC_LO];
      n.auto_smp = bus.wdata[`ADCSEQ_AUTO_BIT];
      n.sample_active     = bus.wdata[`ADCSEQ_SAMPLE_ACTIVE_BIT];
    end
    if (bus.wr && reg_hit(bus.addr, `ADCSEQ_CLK_OFS)) begin
      n.rc_sel = bus.wdata[`ADCSEQ_RC_BIT];
      n.stc    = bus.wdata[`ADCSEQ_STC_HI:`ADCSEQ_STC_LO];
      n.pre    = bus.wdata[`ADCSEQ_PRE_HI:`ADCSEQ_PRE_LO];
    end
    if (bus.rd) begin
      n.rdata = rd_word(bus.addr, q);
    end

    // Hardware updates follow the write, so a hardware set wins
    case (q.state)
      ADCSEQ_IDLE: begin
        // Off: nothing runs, register contents stay
        // Auto enable also starts the free-running clocked mode
        if (q.on && (q.sample_active || q.auto_smp)) begin
          n.sample_active  = 1'b1;
          n.state = ADCSEQ_SAMPLE;
          n.cnt   = 5'h00;
        end
      end
      ADCSEQ_SAMPLE: begin
        // Power down ends sampling with no conversion
        if (!q.on) begin
          n.state = ADCSEQ_IDLE;
        end else if (trig) begin
          // Done drops together with sample_active
          n.sample_active       = 1'b0;
          n.done       = 1'b0;
          n.state      = ADCSEQ_CONVERT;
          n.cnt        = 5'h00;
          n.conv_start = 1'b1;
        end else if (!n.sample_active) begin
          // Other sources: clearing only stops sampling
          n.state = ADCSEQ_IDLE;
        end else if (tad_tick) begin
          n.cnt = q.cnt + 5'h01;
        end
      end
      ADCSEQ_CONVERT: begin
        if (!q.on) begin
          // No result strobe, buffer keeps its old word
          n.abort = 1'b1;
          n.state = ADCSEQ_IDLE;
        end else if (tad_tick) begin
          // Counts conversion clock periods, never system clocks
          if (q.cnt == (`ADCSEQ_CONV_TAD - 5'h01)) begin
            n.done         = 1'b1;
            n.result_write = 1'b1;
            // During a run auto enable is sampled only here, so clearing it mid-run stops later
            if (q.auto_smp) begin
              n.sample_active     = 1'b1;
              n.state    = ADCSEQ_SAMPLE;
              n.chan_adv = 1'b1;
              n.cnt      = 5'h00;
            end else begin
              n.state = ADCSEQ_IDLE;
            end
          end else begin
            n.cnt = q.cnt + 5'h01;
          end
        end
      end
      default: begin
        n.state = ADCSEQ_IDLE;
      end
    endcase
    n.sampling   = (n.state == ADCSEQ_SAMPLE);
    n.converting = (n.state == ADCSEQ_CONVERT);
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Reset fields from the reset words, cut to their widths
      q      <= '0;
      q.src  <= 4'(`ADCSEQ_CTRL_RST >> `ADCSEQ_SRC_LO);
      q.pre  <= 8'(`ADCSEQ_CLK_RST);
    end else if (ce) begin
      q <= n;
    end
  end

  // Outputs straight from flops
  assign rd_data      = q.rdata;
  assign powered      = q.on;
  assign sampling     = q.sampling;
  assign converting   = q.converting;
  assign conv_start   = q.conv_start;
  assign result_write = q.result_write;
  assign chan_advance = q.chan_adv;
  assign conv_abort   = q.abort;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_conv_end;
    q.state == ADCSEQ_CONVERT && ce && q.on && tad_tick
      && q.cnt == (`ADCSEQ_CONV_TAD - 5'h01);
  endsequence

  sequence s_sample_active_live;
    q.state == ADCSEQ_SAMPLE && ce && q.on;
  endsequence

  a_sw_trigger: assert property (@(posedge clk) disable iff (!rst_b)
    s_sample_active_live and (q.src == `ADCSEQ_SRC_SW && sw_clr)
      |=> q.state == ADCSEQ_CONVERT && !q.sample_active && !q.done && conv_start)
    else $error("software clear did not start conversion");

  a_conv_length: assert property (@(posedge clk) disable iff (!rst_b)
    s_conv_end |=> result_write && q.done)
    else $error("conversion did not end after twelve periods");

  a_auto_restart: assert property (@(posedge clk) disable iff (!rst_b)
    s_conv_end and q.auto_smp
      |=> q.state == ADCSEQ_SAMPLE && q.sample_active && chan_advance ##1 !chan_advance)
    else $error("auto sampling did not restart");

  a_manual_hold: assert property (@(posedge clk) disable iff (!rst_b)
    s_conv_end and !q.auto_smp |=> !q.sample_active && q.done && q.state == ADCSEQ_IDLE)
    else $error("manual mode resumed or not inactive");

  a_clocked_end: assert property (@(posedge clk) disable iff (!rst_b)
    s_sample_active_live and (q.src == `ADCSEQ_SRC_AUTO && tad_tick
      && (q.cnt + 5'h01) == q.stc) |=> q.state == ADCSEQ_CONVERT)
    else $error("clocked sample time not honoured");

  a_pin_edge: assert property (@(posedge clk) disable iff (!rst_b)
    s_sample_active_live and (q.src == `ADCSEQ_SRC_PIN && pin_edge)
      |=> $fell(q.sample_active) && converting)
    else $error("pin edge did not start conversion");

  a_timer_match: assert property (@(posedge clk) disable iff (!rst_b)
    s_sample_active_live and (q.src == `ADCSEQ_SRC_TMR && tmr_evt)
      |=> conv_start ##1 !conv_start)
    else $error("timer match did not start conversion");

  a_off_abort: assert property (@(posedge clk) disable iff (!rst_b)
    q.state == ADCSEQ_CONVERT && ce && !q.on
      |=> conv_abort && !result_write && q.state == ADCSEQ_IDLE)
    else $error("conversion not aborted on power down");

  a_ignore_trig: assert property (@(posedge clk) disable iff (!rst_b)
    q.state == ADCSEQ_CONVERT && ce && q.on && !tad_tick
      |=> q.state == ADCSEQ_CONVERT && !conv_start)
    else $error("event acted outside sampling");

  a_manual_start: assert property (@(posedge clk) disable iff (!rst_b)
    q.state == ADCSEQ_IDLE && ce && q.on && q.sample_active |=> sampling)
    else $error("sampling did not begin");

  // Status, gating and channel stepping
  sequence s_idle_on;
    q.state == ADCSEQ_IDLE && ce && q.on;
  endsequence

  a_free_run: assert property (@(posedge clk) disable iff (!rst_b)
    s_conv_end and (q.src == `ADCSEQ_SRC_AUTO && q.auto_smp)
      |=> sampling && q.cnt == 5'h00)
    else $error("free-running mode did not resample");

  a_start_gate: assert property (@(posedge clk) disable iff (!rst_b)
    q.state != ADCSEQ_SAMPLE && ce |=> !conv_start)
    else $error("conversion started outside sampling");

  a_done_clear: assert property (@(posedge clk) disable iff (!rst_b)
    conv_start |-> !q.sample_active && !q.done && converting)
    else $error("done still set at conversion start");

  a_inactive_show: assert property (@(posedge clk) disable iff (!rst_b)
    s_conv_end and !q.auto_smp |=> result_write && !sampling && q.done)
    else $error("inactive status not shown");

  a_off_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !q.on && ce |=> !sampling && !converting)
    else $error("sequencer ran while powered down");

  a_one_channel: assert property (@(posedge clk) disable iff (!rst_b)
    result_write && !sampling |-> !chan_advance)
    else $error("channel advanced without auto sampling");

  a_auto_idle: assert property (@(posedge clk) disable iff (!rst_b)
    s_idle_on and q.auto_smp |=> sampling && q.sample_active)
    else $error("auto sampling did not start from idle");

  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(q))
    else $error("state moved while clock enable was low");

endmodule // adcseq_core
`default_nettype wire

// File: testbench/adcseq_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcseq_far_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Bench commands
  input  wire logic        pin_lvl,
  input  wire logic [3:0]  trig_idx,
  input  wire logic        trig_go,
  input  wire logic [31:0] period,
  // Event sources
  output logic             ext_int_pin,
  output logic [15:0]      ext_trig,
  output logic [31:0]      paired_timer_count,
  output logic [31:0]      paired_timer_period,
  output logic             rc_osc
);
  logic [1:0] rc_div;
  //////////////////////////////////////////////////////////////////
  // Pin and period pass straight through
  assign ext_int_pin         = pin_lvl;
  assign paired_timer_period = period;
  // Timer wraps after the match, one event a period; RC runs free
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      paired_timer_count <= '0;
      ext_trig           <= '0;
      rc_div             <= '0;
      rc_osc             <= 1'b0;
    end else begin
      paired_timer_count <= (paired_timer_count >= period) ? '0 : paired_timer_count + 1;
      ext_trig           <= trig_go ? (16'h0001 << trig_idx) : '0;
      rc_div             <= rc_div + 2'd1;
      if (rc_div == 2'd3) rc_osc <= ~rc_osc; // 8 clocks a period
    end
  end
endmodule // adcseq_far_model
`default_nettype wire

// File: testbench/adc_sample_convert_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_regs.svh"
module adc_sample_convert_sequencer_bench import adcseq_pkg::*;;
  logic clk, rst_b, ce, pin_lvl, trig_go, ext_int_pin, rc_osc, powered, sampling;
  logic converting, conv_start, result_write, chan_advance, conv_abort, sample_active_d;
  logic [3:0] trig_idx, exp_src;
  logic [15:0] rd_data, ext_trig, v;
  logic [31:0] paired_timer_count, paired_timer_period, period;
  logic [1:0] hit_q;
  adcseq_bus_t bus;
  int n_errors, checked, n, p, s;
  bit in_conv, exp_auto;
  //////////////////////////////////////////////////////////////////
  // Design and far side
  adcseq_core i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .bus(bus), .rd_data(rd_data),
    .ext_trig(ext_trig), .ext_int_pin(ext_int_pin), .paired_timer_count(paired_timer_count),
    .paired_timer_period(paired_timer_period), .rc_osc(rc_osc), .powered(powered),
    .sampling(sampling), .converting(converting), .conv_start(conv_start),
    .result_write(result_write), .chan_advance(chan_advance), .conv_abort(conv_abort));
  adcseq_far_model i_far (.clk(clk), .rst_b(rst_b), .pin_lvl(pin_lvl), .trig_idx(trig_idx),
    .trig_go(trig_go), .period(period), .ext_int_pin(ext_int_pin), .ext_trig(ext_trig),
    .paired_timer_count(paired_timer_count), .paired_timer_period(paired_timer_period),
    .rc_osc(rc_osc));
  //////////////////////////////////////////////////////////////////
  // Clock; watchdog well beyond the expected run
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2_000_000;
    n_errors++;
    stop_test();
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus cycles; model copy of the control word follows the taken edge
  task automatic bw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '0;
    #1;
    if (a == `ADCSEQ_CTRL_OFS) begin
      exp_auto = d[2];
      exp_src = d[7:4];
    end
  endtask
  task automatic br(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus <= '0;
    #1 d = rd_data;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return sampling;
      1: return conv_start;
      2: return result_write;
      default: return conv_abort;
    endcase
  endfunction
  // Bounded wait; k is the cycle count, lim when nothing came
  task automatic wt(input int w, input int lim, output int k);
    for (k = 0; k < lim; k++) begin
      #1;
      if (sel(w) === 1'b1) break;
      @(posedge clk);
    end
  endtask
  task automatic pulse(input int c);
    @(posedge clk) trig_go <= 1'b1;
    trig_idx <= c[3:0];
    @(posedge clk) trig_go <= 1'b0;
  endtask
  task automatic conv_len(input int lo, input int hi);
    wt(2, hi + 2, n);
    chk("conversion length", n >= lo && n <= hi, 1);
  endtask
  //////////////////////////////////////////////////////////////////
  // Reference model, checked at every start and result
  always @(posedge clk) begin
    if (rst_b) begin
      if (conv_start) begin
        chk("start only from sampling", sample_active_d, 1);
        if (exp_src == `ADCSEQ_SRC_TMR) chk("timer match", |hit_q, 1);
        in_conv = 1;
      end
      if (result_write) begin
        chk("result in conversion", in_conv, 1);
        chk("chan_advance", chan_advance, exp_auto);
        in_conv = 0;
      end
      if (conv_abort) in_conv = 0;
      hit_q = {hit_q[0], paired_timer_count === paired_timer_period};
      sample_active_d = sampling;
    end else in_conv = 0;
  end
  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bus = '0;
    ce = 1'b1;
    rst_b = 1'b0;
    pin_lvl = 1'b0;
    trig_idx = '0;
    trig_go = 1'b0;
    period = 32'd40;
    void'($urandom(32'hde23));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    br(`ADCSEQ_CTRL_OFS, v); chk("ctrl reset", v, `ADCSEQ_CTRL_RST);
    br(`ADCSEQ_CLK_OFS, v); chk("clk reset", v, `ADCSEQ_CLK_RST);
    br(4'h8, v); chk("unmapped read", v, 16'h0000);
    $display("test reset done");
    // Manual sample, software trigger
    p = $urandom_range(3);
    s = $urandom_range(31, 1);
    bw(`ADCSEQ_CLK_OFS, {3'b000, s[4:0], p[7:0]});
    bw(0, 16'h8002);
    wt(0, 4, n); chk("sample start", n, 1);
    bw(0, 16'h8000);
    wt(1, 2, n); chk("software trigger", n, 0);
    conv_len(11 * (p + 1), 12 * (p + 1) + 1);
    br(0, v); chk("inactive status", v, 16'h8001);
    repeat (20) @(posedge clk);
    #1 chk("no resample", sampling, 0);
    $display("test manual done");
    // Free-running clocked sequences, then auto enable cleared
    bw(0, 16'h0070);
    bw(0, 16'h8074);
    wt(0, 4, n);
    for (int i = 0; i < 3; i++) begin
      wt(1, 40 * (p + 1), n);
      chk("sample time", n >= (s - 1) * (p + 1) && n <= s * (p + 1) + 1, 1);
      conv_len(11 * (p + 1), 12 * (p + 1) + 1);
      chk("restart sampling", sampling, 1);
    end
    wt(1, 40 * (p + 1), n);
    bw(0, 16'h8070);
    conv_len(9 * (p + 1), 12 * (p + 1) + 1);
    repeat (10) @(posedge clk);
    #1 chk("no sampling after auto off", sampling, 0);
    $display("test clocked done");
    // Auto sampling with software trigger
    bw(0, 16'h0000);
    bw(0, 16'h8006);
    wt(0, 4, n);
    bw(0, 16'h8004);
    conv_len(11 * (p + 1), 12 * (p + 1) + 1);
    br(0, v); chk("hardware sets sample", v & 16'hfffe, 16'h8006);
    bw(0, 16'h8000);
    conv_len(11 * (p + 1), 12 * (p + 1) + 1);
    $display("test auto done");
    // Abort by converter off
    bw(0, 16'h8002);
    wt(0, 4, n);
    bw(0, 16'h8000);
    br(0, v); chk("done cleared", v, 16'h8000);
    bw(0, 16'h0000);
    wt(3, 3, n); chk("abort pulse", n < 3, 1);
    wt(2, 14 * (p + 1), n); chk("no result after abort", n, 14 * (p + 1));
    chk("powered down", {powered, converting}, 0);
    br(`ADCSEQ_CLK_OFS, v); chk("clk kept", v, {3'b000, s[4:0], p[7:0]});
    $display("test abort done");
    // Pin trigger, both polarities, wrong edge first
    for (int pol = 0; pol < 2; pol++) begin
      @(posedge clk) pin_lvl <= pol[0];
      bw(0, {7'h00, pol[0], 8'h10});
      bw(0, {7'h40, pol[0], 8'h12});
      repeat (4) @(posedge clk);
      @(posedge clk) pin_lvl <= ~pol[0];
      wt(1, 10, n); chk("wrong edge ignored", n, 10);
      @(posedge clk) pin_lvl <= pol[0];
      wt(1, 10, n); chk("pin edge trigger", n < 10, 1);
      conv_len(11 * (p + 1), 12 * (p + 1) + 1);
    end
    $display("test pin done");
    // Timer period match
    @(posedge clk) period <= $urandom_range(60, 20);
    bw(0, 16'h0020);
    bw(0, 16'h8022);
    wt(1, 70, n); chk("timer trigger", n < 70, 1);
    conv_len(11 * (p + 1), 12 * (p + 1) + 1);
    $display("test timer done");
    // Other event codes: ignored while idle, taken while sampling
    for (int c = 3; c < 16; c++) begin
      if (c == 7) continue;
      bw(0, {8'h00, c[3:0], 4'h0});
      bw(0, {8'h80, c[3:0], 4'h0});
      pulse(c);
      wt(1, 6, n); chk("idle event ignored", n, 6);
      bw(0, {8'h80, c[3:0], 4'h2});
      pulse(c);
      wt(1, 4, n); chk("event trigger", n < 4, 1);
      conv_len(11 * (p + 1), 12 * (p + 1) + 1);
    end
    $display("test events done");
    // RC clock, 8 system clocks a period
    bw(`ADCSEQ_CLK_OFS, {1'b1, 2'b00, 5'd2, 8'h00});
    bw(0, 16'h0070);
    bw(0, 16'h8072);
    wt(1, 60, n);
    conv_len(84, 104);
    $display("test rc done");
    // Clock enable low: a write in that time is lost, state holds
    @(posedge clk) ce <= 1'b0;
    bus <= '{addr: `ADCSEQ_CTRL_OFS, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus <= '0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    br(0, v); chk("frozen by clock enable", v, 16'h8071);
    $display("test freeze done");
    stop_test();
  end
endmodule // adc_sample_convert_sequencer_bench
`default_nettype wire
